// File: logic/ppc_pkg.sv
// Package for the port pin configuration block: offsets, resets, pin masks, carriers
package ppc_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the I/O register space (chosen)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE_A  = 8'h02;
  localparam logic [7:0] OFF_MODE_B  = 8'h03;
  localparam logic [7:0] OFF_DIR_A   = 8'h04;
  localparam logic [7:0] OFF_DIR_B   = 8'h05;
  localparam logic [7:0] OFF_DIR_C   = 8'h12;
  localparam logic [7:0] OFF_DIR_D   = 8'h13;
  localparam logic [7:0] OFF_DRV_A   = 8'h06;
  localparam logic [7:0] OFF_DRV_B   = 8'h07;
  localparam logic [7:0] OFF_DRV_C   = 8'h16;
  localparam logic [7:0] OFF_DRV_D   = 8'h17;
  localparam logic [7:0] OFF_MEMMAP  = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam int         MEMMAP_PIO_BIT = 7;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // Per-port pin capability masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_MASK_D   = 8'h06; // Port D has pins 2 and 1 only
  localparam logic [7:0] OD_MASK_AB   = 8'hF0; // Open drain on high nibble
  localparam logic [7:0] SLEW_MASK_AB = 8'h0F; // Slew on low nibble
  localparam logic [7:0] OD_MASK_C    = 8'hFF;
  localparam logic [7:0] SLEW_MASK_D  = 8'h06;
  localparam logic [7:0] BC_MASK_C    = 8'h9C; // Shared macrocells on pins 7,4,3,2
  localparam logic [7:0] JTAG_MASK_C  = 8'h00; // Parameter default in top

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] outEn;     // Driver enable, 1 = driving
    logic [7:0] openDrain; // 1 = open drain driver
    logic [7:0] fastSlew;  // 1 = fast slew
    logic [7:0] dataOut;   // Level driven when enabled
  } ppc_pin_ctl_s;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppc_bus_req_s;

endpackage : ppc_pkg

// File: logic/ppc_port_drive.sv
// One port's pin driver logic: output enable, source select, drive style
`timescale 1ns/1ps

module ppc_port_drive
  import ppc_pkg::*;
#(
  parameter logic [7:0] OD_MASK   = 8'h00,
  parameter logic [7:0] SLEW_MASK = 8'h00,
  parameter logic [7:0] PIN_MASK  = 8'hFF
) (
  // Configuration
  input  wire logic [7:0] modeSel,
  input  wire logic [7:0] dirReg,
  input  wire logic [7:0] driveSel,
  // Sources
  input  wire logic [7:0] oeTerm,
  input  wire logic [7:0] mcuData,
  input  wire logic [7:0] addrLatch,
  input  wire logic [7:0] plaData,
  input  wire logic [7:0] plaOwn,
  // Result
  output      ppc_pin_ctl_s pinCtl
);

  // ----------------------------------------------------------------
  // Combine configuration into pin controls, bit n acts on pin n
  // ----------------------------------------------------------------
  always_comb begin
    // OR of direction and oe term
    pinCtl.outEn     = (dirReg | oeTerm) & PIN_MASK;
    pinCtl.openDrain = driveSel & OD_MASK & PIN_MASK;
    pinCtl.fastSlew  = driveSel & SLEW_MASK & PIN_MASK;
    // mode bit picks address or MCU data
    pinCtl.dataOut   = (plaOwn & plaData)
                     | (~plaOwn & ((modeSel & addrLatch) | (~modeSel & mcuData)));
  end

endmodule // ppc_port_drive

// File: logic/ppc_port_config.sv
// Top of the port pin configuration block: registers, bus access and pin drive
`timescale 1ns/1ps

module ppc_port_config
  import ppc_pkg::*;
#(
  parameter logic [7:0] JTAG_PINS_C = JTAG_MASK_C
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Register bus from the microcontroller
  input  wire ppc_bus_req_s busReq,
  output      logic [7:0]   busRdata,
  // Microcontroller sources
  input  wire logic [7:0]   addrLow,
  input  wire logic [7:0]   mcuDataA,
  input  wire logic [7:0]   mcuDataB,
  input  wire logic [7:0]   mcuDataC,
  input  wire logic [7:0]   mcuDataD,
  input  wire logic [7:0]   cpuBusOut,
  input  wire logic         cpuBusDrive,
  // Logic array sources
  input  wire logic [31:0]  oeTerms,
  input  wire logic [7:0]   abMacrocellOutput,
  input  wire logic [7:0]   abRouteA,
  input  wire logic [7:0]   abRouteB,
  input  wire logic [7:0]   bcMacrocellOutput,
  input  wire logic [7:0]   bcRouteB,
  input  wire logic [7:0]   bcRouteC,
  input  wire logic [7:0]   chipSelD,
  input  wire logic [7:0]   chipSelOwnD,
  // Pin controls
  output      ppc_pin_ctl_s pinA,
  output      ppc_pin_ctl_s pinB,
  output      ppc_pin_ctl_s pinC,
  output      ppc_pin_ctl_s pinD,
  output      logic         peripheralBufferEnable
);

  // Refuse a JTAG pin set that collides with the shared macrocell pins
  if ((JTAG_PINS_C & BC_MASK_C) != 8'h00) begin : g_bad_jtag_pins
    $error("JTAG pins overlap shared macrocell pins");
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] modeA, modeB;
  logic [7:0] dirA, dirB, dirC, dirD;
  logic [7:0] drvA, drvB, drvC, drvD;
  logic [7:0] memoryMapControl;
  logic       wrEn;

  assign wrEn = busReq.sel & busReq.wr;

  // Register writes at fixed offsets
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeA <= CFG_RESET;
      modeB <= CFG_RESET;
      dirA <= CFG_RESET;
      dirB <= CFG_RESET;
      dirC <= CFG_RESET;
      dirD <= CFG_RESET;
      drvA <= CFG_RESET;
      drvB <= CFG_RESET;
      drvC <= CFG_RESET;
      drvD <= CFG_RESET;
      memoryMapControl <= CFG_RESET;
    end else if (wrEn) begin
      if (busReq.addr == OFF_MODE_A) begin
        modeA <= busReq.wdata;
      end else if (busReq.addr == OFF_MODE_B) begin
        modeB <= busReq.wdata;
      end else if (busReq.addr == OFF_DIR_A) begin
        dirA <= busReq.wdata;
      end else if (busReq.addr == OFF_DIR_B) begin
        dirB <= busReq.wdata;
      end else if (busReq.addr == OFF_DIR_C) begin
        dirC <= busReq.wdata;
      end else if (busReq.addr == OFF_DIR_D) begin
        dirD <= busReq.wdata;
      end else if (busReq.addr == OFF_DRV_A) begin
        drvA <= busReq.wdata;
      end else if (busReq.addr == OFF_DRV_B) begin
        drvB <= busReq.wdata;
      end else if (busReq.addr == OFF_DRV_C) begin
        drvC <= busReq.wdata;
      end else if (busReq.addr == OFF_DRV_D) begin
        drvD <= busReq.wdata;
      end else if (busReq.addr == OFF_MEMMAP) begin
        memoryMapControl <= busReq.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back, registered one cycle after the read strobe
  // ----------------------------------------------------------------
  logic [7:0] next_busRdata;

  always_comb begin
    if (busReq.addr == OFF_MODE_A) begin
      next_busRdata = modeA;
    end else if (busReq.addr == OFF_MODE_B) begin
      next_busRdata = modeB;
    end else if (busReq.addr == OFF_DIR_A) begin
      next_busRdata = dirA;
    end else if (busReq.addr == OFF_DIR_B) begin
      next_busRdata = dirB;
    end else if (busReq.addr == OFF_DIR_C) begin
      next_busRdata = dirC;
    end else if (busReq.addr == OFF_DIR_D) begin
      next_busRdata = dirD;
    end else if (busReq.addr == OFF_DRV_A) begin
      next_busRdata = drvA;
    end else if (busReq.addr == OFF_DRV_B) begin
      next_busRdata = drvB;
    end else if (busReq.addr == OFF_DRV_C) begin
      next_busRdata = drvC;
    end else if (busReq.addr == OFF_DRV_D) begin
      next_busRdata = drvD;
    end else if (busReq.addr == OFF_MEMMAP) begin
      next_busRdata = memoryMapControl;
    end else begin
      next_busRdata = READ_UNMAPPED;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= 8'h00;
    end else if (busReq.sel & busReq.rd) begin
      busRdata <= next_busRdata;
    end
  end

  // ----------------------------------------------------------------
  // Source selection per port
  // ----------------------------------------------------------------
  logic [7:0] plaDataA, plaOwnA, plaDataB, plaOwnB, plaOwnC;
  logic [7:0] bcOwnC, dirDActive, mcuA;
  logic       pioOn;

  // latched address byte maps low nibble a3-a0, high a7-a4
  // peripheral mode makes port A carry the MCU data bus
  assign pioOn    = memoryMapControl[MEMMAP_PIO_BIT];
  assign mcuA     = pioOn ? cpuBusOut : mcuDataA;
  assign plaOwnA  = pioOn ? 8'h00 : abRouteA;
  assign plaDataA = abMacrocellOutput;
  assign plaOwnB  = abRouteB | bcRouteB;
  assign plaDataB = (abRouteB & abMacrocellOutput) | (bcRouteB & bcMacrocellOutput);
  // shared macrocells only on allowed pins
  assign bcOwnC   = bcRouteC & BC_MASK_C;
  // JTAG pins excluded from port C logic ownership
  assign plaOwnC  = bcOwnC & ~JTAG_PINS_C;
  // only two direction bits reach port D
  assign dirDActive = dirD & DIR_MASK_D;

  ppc_pin_ctl_s ctlA, ctlB, ctlC, ctlD;
  logic [7:0]   oeA;

  // buffer drives only while the MCU bus drives
  assign oeA = pioOn ? {8{cpuBusDrive}} : oeTerms[7:0];

  ppc_port_drive #(.OD_MASK(OD_MASK_AB), .SLEW_MASK(SLEW_MASK_AB), .PIN_MASK(8'hFF)) uDrvA (
    .modeSel   (pioOn ? 8'h00 : modeA),
    .dirReg    (pioOn ? 8'h00 : dirA),
    .driveSel  (drvA),
    .oeTerm    (oeA),
    .mcuData   (mcuA),
    .addrLatch (addrLow),
    .plaData   (plaDataA),
    .plaOwn    (plaOwnA),
    .pinCtl    (ctlA)
  );

  ppc_port_drive #(.OD_MASK(OD_MASK_AB), .SLEW_MASK(SLEW_MASK_AB), .PIN_MASK(8'hFF)) uDrvB (
    .modeSel   (modeB),
    .dirReg    (dirB),
    .driveSel  (drvB),
    .oeTerm    (oeTerms[15:8]),
    .mcuData   (mcuDataB),
    .addrLatch (addrLow),
    .plaData   (plaDataB),
    .plaOwn    (plaOwnB),
    .pinCtl    (ctlB)
  );

  // port C has no mode register
  ppc_port_drive #(.OD_MASK(OD_MASK_C), .SLEW_MASK(8'h00), .PIN_MASK(~JTAG_PINS_C)) uDrvC (
    .modeSel   (8'h00),
    .dirReg    (dirC),
    .driveSel  (drvC),
    .oeTerm    (oeTerms[23:16]),
    .mcuData   (mcuDataC),
    .addrLatch (8'h00),
    .plaData   (bcMacrocellOutput),
    .plaOwn    (plaOwnC),
    .pinCtl    (ctlC)
  );

  // port D has no mode register
  ppc_port_drive #(.OD_MASK(8'h00), .SLEW_MASK(SLEW_MASK_D), .PIN_MASK(DIR_MASK_D)) uDrvD (
    .modeSel   (8'h00),
    .dirReg    (dirDActive),
    .driveSel  (drvD),
    .oeTerm    (oeTerms[31:24]),
    .mcuData   (mcuDataD),
    .addrLatch (8'h00),
    .plaData   (chipSelD),
    .plaOwn    (chipSelOwnD & DIR_MASK_D),
    .pinCtl    (ctlD)
  );

  // ----------------------------------------------------------------
  // Registered pin controls
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinA <= '0;
      pinB <= '0;
      pinC <= '0;
      pinD <= '0;
      peripheralBufferEnable <= 1'b0;
    end else begin
      pinA <= ctlA;
      pinB <= ctlB;
      pinC <= ctlC;
      pinD <= ctlD;
      peripheralBufferEnable <= pioOn;
    end
  end

endmodule // ppc_port_config

// File: tb/ppc_port_config_sva.sv
// Checker for the port pin configuration block
`timescale 1ns/1ps
module ppc_port_config_sva
  import ppc_pkg::*;
(
  // Clock, reset and bus
  input wire logic         sys_clk,
  input wire logic         arst_n,
  input wire ppc_bus_req_s busReq,
  input wire logic [7:0]   busRdata,
  // Pin side
  input wire logic [31:0]  oeTerms,
  input wire ppc_pin_ctl_s pinA,
  input wire ppc_pin_ctl_s pinB,
  input wire ppc_pin_ctl_s pinD,
  input wire logic         peripheralBufferEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Pin drive relations
  a_oe_term_on: assert property (
    |oeTerms[15:8] |=> (pinB.outEn & $past(oeTerms[15:8])) == $past(oeTerms[15:8]))
    else $error("oe term did not enable port B");
  a_dir_to_pin: assert property (
    busReq.sel && busReq.wr && busReq.addr == OFF_DIR_B ##1 oeTerms[15:8] == 8'h00
    |=> pinB.outEn == $past(busReq.wdata, 2)) else $error("port B enable not from direction");
  a_od_low_zero: assert property (
    (pinA.openDrain & ~OD_MASK_AB) == 8'h00) else $error("open drain on slew pins");
  a_slew_high_zero: assert property (
    (pinB.fastSlew & ~SLEW_MASK_AB) == 8'h00) else $error("fast slew on drain pins");
  a_portd_two_pins: assert property (
    ((pinD.outEn | pinD.fastSlew | pinD.openDrain) & ~DIR_MASK_D) == 8'h00)
    else $error("port D unused pin active");
  // Register access relations
  a_write_readback: assert property (
    busReq.sel && busReq.wr && busReq.addr == OFF_DIR_A
    ##1 busReq.sel && busReq.rd && busReq.addr == OFF_DIR_A
    |=> busRdata == $past(busReq.wdata, 2)) else $error("readback differs from write");
  a_unmapped_zero: assert property (
    busReq.sel && busReq.rd && busReq.addr == 8'h40 |=> busRdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_pio_flag: assert property (
    busReq.sel && busReq.wr && busReq.addr == OFF_MEMMAP
    |-> ##2 peripheralBufferEnable == $past(busReq.wdata[MEMMAP_PIO_BIT], 2))
    else $error("buffer enable not from bit 7");
endmodule // ppc_port_config_sva

// File: tb/ppc_mcu_model.sv
// Microcontroller bus master model for the configuration registers
`timescale 1ns/1ps
module ppc_mcu_model
  import ppc_pkg::*;
(
  // Clock and bus
  input  wire logic         sys_clk,
  output      ppc_bus_req_s busReq,
  input  wire logic [7:0]   busRdata
);
  initial busReq = '0;
  // Released bus shows inverted leftovers
  task automatic idle();
    busReq = '{1'b0, 1'b0, 1'b0, ~busReq.addr, ~busReq.wdata};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq = '{1'b1, 1'b1, 1'b0, a, d};
    @(negedge sys_clk);
  endtask
  // plain read cycle, data a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    busReq = '{1'b1, 1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    idle();
    @(negedge sys_clk);
    d = busRdata;
  endtask
endmodule // ppc_mcu_model

// File: tb/ppc_port_config_tb_top.sv
// Testbench for the port pin configuration block
`timescale 1ns/1ps
module ppc_port_config_tb_top
  import ppc_pkg::*;
  ;
  logic         sys_clk = 1'b0;
  logic         arst_n  = 1'b0;
  ppc_bus_req_s busReq;
  localparam logic [7:0] JTAG_TB_C = 8'h63; // Four JTAG pins clear of shared macrocell pins
  logic [7:0]   busRdata, addrLow, cpuBusOut, abOut, bcOut, csD, rv;
  logic [7:0]   abRouteA, abRouteB, bcRouteB, bcRouteC, chipSelOwnD;
  logic         cpuBusDrive, peripheralBufferEnable;
  logic [31:0]  oeTerms;
  logic [7:0]   mcu [4];
  ppc_pin_ctl_s pin [4];
  logic [7:0]   mdl [256];
  logic [7:0]   offs [11] = '{OFF_DIR_A, OFF_DIR_B, OFF_DIR_C, OFF_DIR_D, OFF_DRV_A,
    OFF_DRV_B, OFF_DRV_C, OFF_DRV_D, OFF_MODE_A, OFF_MODE_B, OFF_MEMMAP};
  logic [7:0]   odM [4]  = '{OD_MASK_AB, OD_MASK_AB, OD_MASK_C, 8'h00};
  logic [7:0]   slM [4]  = '{SLEW_MASK_AB, SLEW_MASK_AB, 8'h00, SLEW_MASK_D};
  logic [7:0]   pinM [4] = '{8'hFF, 8'hFF, ~JTAG_TB_C, DIR_MASK_D};
  int           err_total = 0, compares = 0, cycles = 0, seed = 32'h59f8;

  always #10 sys_clk = ~sys_clk;

  ppc_mcu_model i_ppc_mcu_model (.sys_clk(sys_clk), .busReq(busReq), .busRdata(busRdata));
  // no pin is a logic input here, so any direction value is legal
  ppc_port_config #(.JTAG_PINS_C(JTAG_TB_C)) i_ppc_port_config (.sys_clk(sys_clk),
    .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata), .addrLow(addrLow),
    .mcuDataA(mcu[0]), .mcuDataB(mcu[1]), .mcuDataC(mcu[2]), .mcuDataD(mcu[3]),
    .cpuBusOut(cpuBusOut), .cpuBusDrive(cpuBusDrive), .oeTerms(oeTerms),
    .abMacrocellOutput(abOut), .abRouteA(abRouteA), .abRouteB(abRouteB),
    .bcMacrocellOutput(bcOut), .bcRouteB(bcRouteB), .bcRouteC(bcRouteC), .chipSelD(csD),
    .chipSelOwnD(chipSelOwnD), .pinA(pin[0]), .pinB(pin[1]), .pinC(pin[2]), .pinD(pin[3]),
    .peripheralBufferEnable(peripheralBufferEnable));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    i_ppc_mcu_model.wr(a, d);
    if (a inside {offs}) mdl[a] = d;
  endtask
  task automatic rdchk(input logic [7:0] a);
    i_ppc_mcu_model.rd(a, rv);
    chk(rv, mdl[a]);
  endtask
  task automatic settle();
    i_ppc_mcu_model.idle();
    repeat (3) @(negedge sys_clk);
  endtask
  // Model of every port's pin controls from stored registers
  task automatic chk_pins();
    logic [7:0] md, en, dat, own, pla;
    for (int p = 0; p < 4; p++) begin
      md = (p < 2) ? mdl[offs[8 + p]] : 8'h00;
      en = (mdl[offs[p]] | oeTerms[8 * p +: 8]) & pinM[p];
      // Logic array ownership: shared macrocells reach port C pins 2,3,4,7 only
      own = (p == 0) ? abRouteA : (p == 1) ? (abRouteB | bcRouteB)
          : (p == 2) ? (bcRouteC & BC_MASK_C) : (chipSelOwnD & DIR_MASK_D);
      pla = (p == 0) ? abOut : (p == 1) ? ((abRouteB & abOut) | (bcRouteB & bcOut))
          : (p == 2) ? bcOut : csD;
      // address shows where mode is set and the logic array does not own the pin
      dat = (own & pla) | (~own & ((md & addrLow) | (~md & mcu[p])));
      if (p == 0 && mdl[OFF_MEMMAP][7]) begin
        en = {8{cpuBusDrive}};
        dat = cpuBusOut;
      end
      chk(pin[p].outEn, en);
      chk(pin[p].openDrain, mdl[offs[4 + p]] & odM[p] & pinM[p]);
      chk(pin[p].fastSlew, mdl[offs[4 + p]] & slM[p] & pinM[p]);
      chk(pin[p].dataOut & en, dat & en);
    end
  endtask
  task automatic rand_in();
    oeTerms = $random(seed) & $random(seed) & $random(seed);
    addrLow = 8'($random(seed));
    foreach (mcu[i]) mcu[i] = 8'($random(seed));
    {abOut, bcOut, csD} = 24'($random(seed));
    {abRouteA, abRouteB, bcRouteB, bcRouteC} = $random(seed) & $random(seed);
    chipSelOwnD = 8'($random(seed));
    cpuBusOut = 8'($random(seed));
    cpuBusDrive = 1'($random(seed));
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    {oeTerms, addrLow, cpuBusOut, cpuBusDrive, abOut, bcOut, csD} = '0;
    {abRouteA, abRouteB, bcRouteB, bcRouteC, chipSelOwnD} = '0;
    mcu = '{default: 8'h00};
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    foreach (offs[i]) rdchk(offs[i]);
    wrm(OFF_DIR_A, 8'h07);
    rdchk(OFF_DIR_A);
    wrm(OFF_DIR_B, 8'h5A);
    settle();
    chk_pins();
    $display("Reset and readback test done");
    repeat (25) begin
      rand_in();
      wrm(offs[$unsigned($random(seed)) % 10], 8'($random(seed)));
      wrm(offs[$unsigned($random(seed)) % 10], 8'($random(seed)));
      rdchk(offs[$unsigned($random(seed)) % 10]);
      settle();
      chk_pins();
    end
    $display("Random configuration test done");
    rand_in();
    wrm(OFF_MEMMAP, 8'h80);
    settle();
    chk({7'h00, peripheralBufferEnable}, 8'h01);
    chk_pins();
    cpuBusDrive = ~cpuBusDrive;
    settle();
    chk_pins();
    wrm(OFF_MEMMAP, 8'h00);
    settle();
    chk({7'h00, peripheralBufferEnable}, 8'h00);
    chk_pins();
    $display("Peripheral buffer test done");
    wrm(8'h40, 8'hFF);
    rdchk(8'h40);
    arst_n = 1'b0;
    @(negedge sys_clk);
    arst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    rdchk(OFF_DIR_C);
    settle();
    chk_pins();
    $display("Unmapped and second reset test done");
    print_verdict();
  end
endmodule // ppc_port_config_tb_top

bind ppc_port_config ppc_port_config_sva i_ppc_port_config_sva (.sys_clk(sys_clk),
  .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata), .oeTerms(oeTerms), .pinA(pinA),
  .pinB(pinB), .pinD(pinD), .peripheralBufferEnable(peripheralBufferEnable));
